// >>> common/nco_defines.svh
// Purpose: Offsets, field positions, reset values and counts of the oscillator.
// Assumes: Included by its bare name; register index times four is the byte address.
// Notes:   Definitions only.
//
// Contract
// - Accumulator is 20 bits, three byte registers.
// - Each input clock edge adds buffered increment.
// - Accumulator carry out is the overflow event.
// - Increment is 20 bits over three bytes.
// - Enabled: low byte write loads buffer, edge two.
// - Disabled: increment writes load buffer at once.
// - Increment buffer is hidden from software.
// - Four-bit select picks one of eleven sources.
// - Fixed duty mode toggles output per overflow.
// - Mode select cleared gives fixed duty mode.
// - Mode select set gives pulse frequency mode.
// - Pulse mode: active some periods, then inactive.
// - Pulse goes active on next input edge.
// - Invert bit sets active and inactive levels.
// - Width select gives two-power-code active periods.
// - Overflow sets flag; software clears it.
// - Polarity change with interrupts enabled sets flag.
// - Reset clears every oscillator register.
`ifndef NCO_DEFINES_SVH
`define NCO_DEFINES_SVH

`define NCO_ACC_WIDTH      20
`define NCO_IDX_ACCL       12'h58C
`define NCO_IDX_ACCH       12'h58D
`define NCO_IDX_ACCU       12'h58E
`define NCO_IDX_INCL       12'h58F
`define NCO_IDX_INCH       12'h590
`define NCO_IDX_INCU       12'h591
`define NCO_IDX_CON        12'h592
`define NCO_IDX_CLK        12'h593
`define NCO_IDX_STAT       12'h594
`define NCO_CON_EN_BIT     7
`define NCO_CON_OUT_BIT    5
`define NCO_CON_POL_BIT    4
`define NCO_CON_PFM_BIT    0
`define OSC_INPUT_CLOCK_PWS_LSB    5
`define OSC_INPUT_CLOCK_CKS_LSB    0
`define NCO_STAT_FLAG_BIT  0
`define NCO_STAT_IE_BIT    1
`define NCO_RST_BYTE       8'h00
`define NCO_LOAD_EDGES     2'd2

`endif

// >>> common/nco_pkg.sv
// Purpose: Types shared by the oscillator design.
// Assumes: nco_defines.svh gives the widths.
// Notes:   The whole block state is one packed struct.
`include "nco_defines.svh"

package nco_pkg;

  typedef enum logic [3:0] {
    NCO_SRC_SYSOSC, NCO_SRC_FASTINT, NCO_SRC_SLOWINT, NCO_SRC_MED500K,
    NCO_SRC_MED32K, NCO_SRC_SECOSC, NCO_SRC_REFCLK, NCO_SRC_LC1,
    NCO_SRC_LC2, NCO_SRC_LC3, NCO_SRC_LC4
  } nco_src_e;

  typedef struct packed {
    logic [`NCO_ACC_WIDTH-1:0] acc;
    logic [`NCO_ACC_WIDTH-1:0] inc;
    logic [`NCO_ACC_WIDTH-1:0] incBuf;
    logic [1:0]                loadCnt;
    logic                      enable;
    logic                      outputInvert;
    logic                      pulseFreqModeSel;
    logic [2:0]                pulseWidthSelect;
    logic [3:0]                inputClockSelect;
    logic                      overflowIrqFlag;
    logic                      irqEnable;
    logic                      srcPrev;
    logic                      rawOut;
    logic                      pfPending;
    logic [6:0]                pulseCnt;
    logic                      outLevel;
    logic [31:0]               prdata;
  } nco_state_s;

endpackage : nco_pkg

// >>> logic/nco_accumulator.sv
// Purpose: Numerically controlled oscillator with an APB register slave.
// Assumes: All source clocks are synchronous to mclk and no faster than mclk/2.
// Notes:   Source rising edges become one-cycle ticks; all logic runs on mclk.
`timescale 1ns/1ps
`default_nettype none
`include "nco_defines.svh"

module nco_accumulator
  import nco_pkg::*;
#(
  parameter int ACC_WIDTH = `NCO_ACC_WIDTH
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Input clock sources
  input  wire logic        systemOscClock,
  input  wire logic        fastInternalOsc,
  input  wire logic        slowInternalOsc,
  input  wire logic        mediumInternalOsc500k,
  input  wire logic        mediumInternalOsc32k,
  input  wire logic        secondaryOsc,
  input  wire logic        referenceClockOut,
  input  wire logic        logicCell1Output,
  input  wire logic        logicCell2Output,
  input  wire logic        logicCell3Output,
  input  wire logic        logicCell4Output,
  // Oscillator output and flag
  output var  logic        ncoOut,
  output var  logic        overflowIrqFlag
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (ACC_WIDTH != `NCO_ACC_WIDTH) begin : gWidthCheck
    $error("nco_accumulator: only the 20-bit accumulator is supported");
  end

  localparam int UPW = ACC_WIDTH - 16;

  // ************************************************************
  // State
  // ************************************************************
  nco_state_s s;
  nco_state_s next_s;

  function automatic logic [15:0] addrOf(input logic [11:0] idx);
    addrOf = {2'b00, idx, 2'b00};
  endfunction : addrOf

  // ************************************************************
  // Source selection and edge tick
  // ************************************************************
  logic srcSel;
  logic tick;

  always_comb begin
    case (s.inputClockSelect)
      NCO_SRC_SYSOSC:  srcSel = systemOscClock;
      NCO_SRC_FASTINT: srcSel = fastInternalOsc;
      NCO_SRC_SLOWINT: srcSel = slowInternalOsc;
      NCO_SRC_MED500K: srcSel = mediumInternalOsc500k;
      NCO_SRC_MED32K:  srcSel = mediumInternalOsc32k;
      NCO_SRC_SECOSC:  srcSel = secondaryOsc;
      NCO_SRC_REFCLK:  srcSel = referenceClockOut;
      NCO_SRC_LC1:     srcSel = logicCell1Output;
      NCO_SRC_LC2:     srcSel = logicCell2Output;
      NCO_SRC_LC3:     srcSel = logicCell3Output;
      NCO_SRC_LC4:     srcSel = logicCell4Output;
      // Reserved codes give a source that never moves
      default:         srcSel = 1'b0;
    endcase
  end

  // Changing the select may produce one stray tick; software should
  // change it while disabled.
  assign tick = srcSel & ~s.srcPrev;

  // ************************************************************
  // Bus decode
  // ************************************************************
  logic        access;
  logic        setup;
  logic        wrByte;
  logic        hit;
  logic [7:0]  wb;
  logic [31:0] rdMux;

  assign access = psel & penable;
  assign setup  = psel & ~penable;
  assign wrByte = access & pwrite & pstrb[0];
  assign wb     = pwdata[7:0];

  always_comb begin
    hit   = 1'b1;
    rdMux = 32'h0000_0000;
    case (paddr)
      addrOf(`NCO_IDX_ACCL): rdMux[7:0] = s.acc[7:0];
      addrOf(`NCO_IDX_ACCH): rdMux[7:0] = s.acc[15:8];
      addrOf(`NCO_IDX_ACCU): rdMux[UPW-1:0] = s.acc[ACC_WIDTH-1:16];
      addrOf(`NCO_IDX_INCL): rdMux[7:0] = s.inc[7:0];
      addrOf(`NCO_IDX_INCH): rdMux[7:0] = s.inc[15:8];
      addrOf(`NCO_IDX_INCU): rdMux[UPW-1:0] = s.inc[ACC_WIDTH-1:16];
      addrOf(`NCO_IDX_CON): begin
        rdMux[`NCO_CON_EN_BIT]  = s.enable;
        rdMux[`NCO_CON_OUT_BIT] = s.outLevel;
        rdMux[`NCO_CON_POL_BIT] = s.outputInvert;
        rdMux[`NCO_CON_PFM_BIT] = s.pulseFreqModeSel;
      end
      addrOf(`NCO_IDX_CLK): begin
        rdMux[`OSC_INPUT_CLOCK_PWS_LSB +: 3] = s.pulseWidthSelect;
        rdMux[`OSC_INPUT_CLOCK_CKS_LSB +: 4] = s.inputClockSelect;
      end
      addrOf(`NCO_IDX_STAT): begin
        rdMux[`NCO_STAT_FLAG_BIT] = s.overflowIrqFlag;
        rdMux[`NCO_STAT_IE_BIT]   = s.irqEnable;
      end
      default: hit = 1'b0;
    endcase
  end

  // The incrementer buffer has no address at all and never reaches rdMux.

  // ************************************************************
  // Next-state logic
  // ************************************************************
  logic [ACC_WIDTH:0] sum;
  logic               carry;
  logic               accTick;
  logic               polEvent;
  logic [6:0]         widthM1;
  logic               wAccL, wAccH, wAccU;
  logic               wIncL, wIncH, wIncU;
  logic               wCon, wClk, wStat;

  assign sum     = {1'b0, s.acc} + {1'b0, s.incBuf};
  assign accTick = tick & s.enable;
  assign carry   = accTick & sum[ACC_WIDTH];
  assign widthM1 = 7'((8'h01 << s.pulseWidthSelect) - 8'h01);

  assign wAccL = wrByte & (paddr == addrOf(`NCO_IDX_ACCL));
  assign wAccH = wrByte & (paddr == addrOf(`NCO_IDX_ACCH));
  assign wAccU = wrByte & (paddr == addrOf(`NCO_IDX_ACCU));
  assign wIncL = wrByte & (paddr == addrOf(`NCO_IDX_INCL));
  assign wIncH = wrByte & (paddr == addrOf(`NCO_IDX_INCH));
  assign wIncU = wrByte & (paddr == addrOf(`NCO_IDX_INCU));
  assign wCon  = wrByte & (paddr == addrOf(`NCO_IDX_CON));
  assign wClk  = wrByte & (paddr == addrOf(`NCO_IDX_CLK));
  assign wStat = wrByte & (paddr == addrOf(`NCO_IDX_STAT));

  // Output transition caused by a polarity write
  assign polEvent = wCon & (wb[`NCO_CON_POL_BIT] != s.outputInvert) & s.irqEnable;

  always_comb begin
    next_s         = s;
    next_s.srcPrev = srcSel;

    // Accumulate on each selected source edge while enabled
    if (accTick) begin
      next_s.acc = sum[ACC_WIDTH-1:0];
    end

    // Output stage
    if (!s.enable) begin
      next_s.rawOut    = 1'b0;
      next_s.pfPending = 1'b0;
      next_s.pulseCnt  = 7'h00;
    end else if (!s.pulseFreqModeSel) begin
      next_s.pfPending = 1'b0;
      if (carry) begin
        next_s.rawOut = ~s.rawOut;
      end
    end else if (tick) begin
      next_s.pfPending = carry;
      if (s.pfPending) begin
        // A new overflow restarts the pulse, so a width longer than the
        // overflow period keeps the output active.
        next_s.rawOut   = 1'b1;
        next_s.pulseCnt = widthM1;
      end else if (s.rawOut) begin
        if (s.pulseCnt == 7'h00) begin
          next_s.rawOut = 1'b0;
        end else begin
          next_s.pulseCnt = s.pulseCnt - 7'h01;
        end
      end
    end

    // Delayed increment load while running
    if (!s.enable) begin
      next_s.loadCnt = 2'd0;
    end else if (tick && s.loadCnt != 2'd0) begin
      next_s.loadCnt = s.loadCnt - 2'd1;
      if (s.loadCnt == 2'd1) begin
        next_s.incBuf = s.inc;
      end
    end

    // Register writes; software has priority over accumulation
    if (wAccL) begin
      next_s.acc[7:0] = wb;
    end
    if (wAccH) begin
      next_s.acc[15:8] = wb;
    end
    if (wAccU) begin
      next_s.acc[ACC_WIDTH-1:16] = wb[UPW-1:0];
    end
    if (wIncL) begin
      next_s.inc[7:0] = wb;
    end
    if (wIncH) begin
      next_s.inc[15:8] = wb;
    end
    if (wIncU) begin
      next_s.inc[ACC_WIDTH-1:16] = wb[UPW-1:0];
    end
    if (wIncL && s.enable) begin
      next_s.loadCnt = `NCO_LOAD_EDGES;
    end
    if ((wIncL || wIncH || wIncU) && !s.enable) begin
      next_s.incBuf = next_s.inc;
    end
    if (wCon) begin
      next_s.enable           = wb[`NCO_CON_EN_BIT];
      next_s.outputInvert     = wb[`NCO_CON_POL_BIT];
      next_s.pulseFreqModeSel = wb[`NCO_CON_PFM_BIT];
    end
    if (wClk) begin
      next_s.pulseWidthSelect = wb[`OSC_INPUT_CLOCK_PWS_LSB +: 3];
      next_s.inputClockSelect = wb[`OSC_INPUT_CLOCK_CKS_LSB +: 4];
    end

    // Sticky flag: a set in the same cycle as a clear wins
    if (wStat) begin
      next_s.irqEnable = wb[`NCO_STAT_IE_BIT];
      if (wb[`NCO_STAT_FLAG_BIT]) begin
        next_s.overflowIrqFlag = 1'b0;
      end
    end
    if (carry || polEvent) begin
      next_s.overflowIrqFlag = 1'b1;
    end

    // Registered output level follows the invert bit
    next_s.outLevel = next_s.rawOut ^ next_s.outputInvert;

    // Read data captured in the setup phase
    if (setup && !pwrite) begin
      next_s.prdata = rdMux;
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign prdata          = s.prdata;
  assign pready          = 1'b1;
  assign pslverr         = access & ~hit;
  assign ncoOut          = s.outLevel;
  assign overflowIrqFlag = s.overflowIrqFlag;

endmodule : nco_accumulator

`default_nettype wire

// >>> tb/nco_chk.sv
// Purpose: Port assertions for the oscillator.
// Assumes: Control fields are shadowed from APB writes.
// Notes:   Bound to every oscillator instance.
`timescale 1ns/1ps
`default_nettype none
`include "nco_defines.svh"
// ****
// Checker
// ****
module nco_chk (
  // Bus
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Sources
  input wire logic        systemOscClock,
  input wire logic        fastInternalOsc,
  input wire logic        slowInternalOsc,
  input wire logic        mediumInternalOsc500k,
  input wire logic        mediumInternalOsc32k,
  input wire logic        secondaryOsc,
  input wire logic        referenceClockOut,
  input wire logic        logicCell1Output,
  input wire logic        logicCell2Output,
  input wire logic        logicCell3Output,
  input wire logic        logicCell4Output,
  // Outputs
  input wire logic        ncoOut,
  input wire logic        overflowIrqFlag
);
  typedef struct packed {
    logic       en, inv, pulse_freq_mode_sel;
    logic [2:0] pulse_width_select;
    logic [3:0] sel;
    logic       prev;
    logic [7:0] cnt;
  } nco_chk_s;
  nco_chk_s    st, next_st;
  logic [10:0] sv;
  logic        bus, cur, tick, act, conWr, clr, polChg, mapped;
  assign sv = {logicCell4Output, logicCell3Output, logicCell2Output, logicCell1Output,
    referenceClockOut, secondaryOsc, mediumInternalOsc32k, mediumInternalOsc500k,
    slowInternalOsc, fastInternalOsc, systemOscClock};
  assign bus = psel && penable && pwrite && pstrb[0];
  assign conWr = bus && paddr[15:2] == `NCO_IDX_CON;
  assign clr = bus && paddr[15:2] == `NCO_IDX_STAT && pwdata[0];
  assign polChg = conWr && pwdata[4] != st.inv;
  // Reserved selects pick nothing, so they can never tick
  assign cur = (st.sel < 4'hB) ? sv[st.sel] : 1'b0;
  assign tick = cur && !st.prev;
  assign act = ncoOut ^ st.inv;
  assign mapped = paddr[1:0] == 2'h0 && paddr[15:2] >= `NCO_IDX_ACCL
    && paddr[15:2] <= `NCO_IDX_STAT;
  always_comb begin
    next_st = st;
    next_st.prev = cur;
    next_st.cnt = act ? st.cnt + {7'h00, tick} : 8'h00;
    if (conWr) begin
      next_st.en = pwdata[7];
      next_st.inv = pwdata[4];
      next_st.pulse_freq_mode_sel = pwdata[0];
    end
    if (bus && paddr[15:2] == `NCO_IDX_CLK) begin
      next_st.pulse_width_select = pwdata[7:5];
      next_st.sel = pwdata[3:0];
    end
    if (!rst_n) next_st = '0;
  end
  always_ff @(posedge mclk) st <= next_st;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Two quiet cycles let a registered output catch up with a control write
  sequence s_steady;
    st.en && $past(st.en) && $past(st.en, 2) && $stable(st.inv) && $stable(st.pulse_freq_mode_sel)
      && st.inv == $past(st.inv, 2);
  endsequence
  a_reset_zero: assert property (disable iff (1'b0)
    !rst_n |=> !ncoOut && !overflowIrqFlag && prdata == 32'h0) else $error("reset value");
  a_flag_sticky: assert property (overflowIrqFlag && !clr |=> overflowIrqFlag)
    else $error("flag lost");
  a_flag_cause: assert property ($rose(overflowIrqFlag) |->
    $past(tick && st.en) || $past(polChg)) else $error("flag without cause");
  a_idle_level: assert property (!st.en && !$past(st.en) && st.inv == $past(st.inv)
    |-> ncoOut == st.inv) else $error("idle level");
  a_fixed_toggle: assert property (s_steady ##0 (!st.pulse_freq_mode_sel && $changed(ncoOut))
    |-> $past(tick)) else $error("toggle off tick");
  a_pulse_start: assert property (s_steady ##0 (st.pulse_freq_mode_sel && $rose(act))
    |-> $past(tick)) else $error("pulse start");
  a_pulse_width: assert property (s_steady ##0 (st.pulse_freq_mode_sel && $fell(act))
    |-> st.cnt == 8'd1 << st.pulse_width_select) else $error("pulse width");
  a_err_decode: assert property (psel && penable |-> pslverr == !mapped)
    else $error("error decode");
endmodule : nco_chk
bind nco_accumulator nco_chk u_chk (.*);
`default_nettype wire

// >>> tb/nco_src_model.sv
// Purpose: Source clocks seen by the oscillator.
// Assumes: One source moves at a time, two mclk per period.
// Notes:   Idle sources rest low.
`timescale 1ns/1ps
`default_nettype none
module nco_src_model (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Control
  input  wire logic        run,
  input  wire logic [3:0]  sel,
  // Sources
  output var  logic [10:0] src
);
  // Even toggle counts leave the source low, so a select change adds no edge
  always_ff @(posedge mclk) begin
    if (!rst_n) src <= '0;
    else if (run && sel < 4'hB) src[sel] <= !src[sel];
  end
endmodule : nco_src_model
`default_nettype wire

// >>> tb/tb.sv
// Purpose: Self-checking bench for the oscillator.
// Assumes: nco_src_model makes one rising edge per two mclk.
// Notes:   Expected values come from an integer model.
`timescale 1ns/1ps
`default_nettype none
`include "nco_defines.svh"
// ****
// Bench
// ****
module tb;
  logic        mclk, rst_n, psel, penable, pwrite, run, win, inv, pErr, lastOut;
  logic        pready, pslverr, ncoOut, overflowIrqFlag;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, sel;
  logic [19:0] v, inc;
  logic [10:0] src;
  wire         systemOscClock, fastInternalOsc, slowInternalOsc, mediumInternalOsc500k;
  wire         mediumInternalOsc32k, secondaryOsc, referenceClockOut, logicCell1Output;
  wire         logicCell2Output, logicCell3Output, logicCell4Output;
  int          numErrors, testsRun, togCnt, actCnt, acc, c, n;
  assign {logicCell4Output, logicCell3Output, logicCell2Output, logicCell1Output,
    referenceClockOut, secondaryOsc, mediumInternalOsc32k, mediumInternalOsc500k,
    slowInternalOsc, fastInternalOsc, systemOscClock} = src;
  nco_accumulator DUT (.*);
  nco_src_model u_src (.mclk(mclk), .rst_n(rst_n), .run(run), .sel(sel), .src(src));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      numErrors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] d);
    int w;
    w = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && w < 50) begin
      @(posedge mclk);
      w++;
    end
    rd = prdata;
    pErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  // Upper and high bytes first, so the low byte write loads a whole value
  task automatic wr20(input logic [11:0] idx, input logic [19:0] x);
    apb(1'b1, idx + 12'd2, {4'h0, x[19:16]});
    apb(1'b1, idx + 12'd1, x[15:8]);
    apb(1'b1, idx, x[7:0]);
  endtask : wr20
  task automatic rd20(input logic [11:0] idx, output logic [19:0] x);
    apb(1'b0, idx, 8'h00);
    x[7:0] = rd[7:0];
    apb(1'b0, idx + 12'd1, 8'h00);
    x[15:8] = rd[7:0];
    apb(1'b0, idx + 12'd2, 8'h00);
    x[19:16] = rd[3:0];
  endtask : rd20
  task automatic ticks(input int k);
    togCnt = 0;
    actCnt = 0;
    @(posedge mclk);
    win <= 1'b1;
    run <= 1'b1;
    repeat (2 * k) @(posedge mclk);
    run <= 1'b0;
    repeat (4) @(posedge mclk);
    win <= 1'b0;
    @(posedge mclk);
  endtask : ticks
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    #160000;
    numErrors++;
    report_and_stop();
  end
  always @(posedge mclk) begin
    if (win && ncoOut !== lastOut) togCnt++;
    if (win && ncoOut !== inv) actCnt++;
    lastOut = ncoOut;
  end
  initial begin
    {rst_n, psel, penable, pwrite, run, win, inv} = '0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
    sel = 4'h0;
    void'($urandom(98194));
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, `NCO_IDX_ACCL + 12'(i), 8'h00);
      check("reset value", 32'h0, rd);
    end
    apb(1'b0, 12'h5A0, 8'h00);
    check("unmapped error", 32'h1, {31'h0, pErr});
    check("unmapped data", 32'h0, rd);
    pstrb <= 4'h0;
    apb(1'b1, `NCO_IDX_ACCL, 8'hA5);
    pstrb <= 4'hF;
    apb(1'b0, `NCO_IDX_ACCL, 8'h00);
    check("strobe refused", 32'h0, rd);
    check("ready level", 32'h1, {31'h0, pready});
    $display("test reset done");
    for (int s = 0; s < 11; s++) begin
      sel <= 4'(s);
      inc = 20'($urandom_range(20'hFFFFF, 1));
      n = $urandom_range(8, 1);
      apb(1'b1, `NCO_IDX_CON, 8'h00);
      apb(1'b1, `NCO_IDX_CLK, 8'(s));
      wr20(`NCO_IDX_INCL, inc);
      wr20(`NCO_IDX_ACCL, 20'h0);
      apb(1'b1, `NCO_IDX_STAT, 8'h01);
      apb(1'b1, `NCO_IDX_CON, 8'h80);
      ticks(n);
      acc = 0;
      c = 0;
      repeat (n) begin
        acc += inc;
        c += acc >> 20;
        acc &= 32'hFFFFF;
      end
      check("toggles", 32'(c), 32'(togCnt));
      apb(1'b1, `NCO_IDX_CON, 8'h00);
      rd20(`NCO_IDX_ACCL, v);
      check("accumulator", 32'(acc), {12'h0, v});
      apb(1'b0, `NCO_IDX_STAT, 8'h00);
      check("flag", 32'(c > 0), rd);
    end
    $display("test sources done");
    wr20(`NCO_IDX_INCL, 20'h12345);
    wr20(`NCO_IDX_ACCL, 20'h0);
    apb(1'b1, `NCO_IDX_CON, 8'h80);
    wr20(`NCO_IDX_INCL, 20'h0ABCD);
    ticks(5);
    apb(1'b1, `NCO_IDX_CON, 8'h00);
    rd20(`NCO_IDX_ACCL, v);
    check("delayed load", (32'h2468A + 32'h20367) & 32'hFFFFF, {12'h0, v});
    rd20(`NCO_IDX_INCL, v);
    check("increment", 32'h0ABCD, {12'h0, v});
    $display("test load done");
    for (int p = 0; p < 4; p++) begin
      for (int q = 0; q < 2; q++) begin
        inv <= q[0];
        apb(1'b1, `NCO_IDX_CLK, {p[2:0], 5'h0A});
        wr20(`NCO_IDX_INCL, 20'h10000);
        wr20(`NCO_IDX_ACCL, 20'h0);
        apb(1'b1, `NCO_IDX_CON, {3'b100, q[0], 4'h1});
        ticks(28);
        check("pulse cycles", 32'(2 << p), 32'(actCnt));
        apb(1'b1, `NCO_IDX_CON, {3'b000, q[0], 4'h0});
        @(negedge mclk);
        check("idle level", 32'(q), {31'h0, ncoOut});
        @(posedge mclk);
      end
    end
    $display("test pulse done");
    apb(1'b1, `NCO_IDX_STAT, 8'h03);
    apb(1'b1, `NCO_IDX_CON, 8'h00);
    apb(1'b0, `NCO_IDX_STAT, 8'h00);
    check("polarity flag", 32'h3, rd);
    $display("test polarity done");
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
